// *** src/tdp_pkg.sv ***
// Constants, field layouts and types of the tamper detect and protect block.
// Assumes a 32-bit AXI4-Lite register bus and a 40 MHz reference clock.
package tdp_pkg;
	// ==========================================================
	// Geometry and timing
	localparam int          N_PINS       = 8;
	localparam int          N_BKP        = 32;
	localparam int          ADDR_W       = 12;
	localparam int          CLK_HZ       = 40_000_000;
	localparam int          TAMP_HZ      = 32_768;
	localparam int          TICK_CYC     = CLK_HZ / TAMP_HZ;
	localparam int          BASE_RATE_TK = TAMP_HZ / 128;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] DETECT_ENABLE_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] FILTER_CFG_OFS    = 12'h004;
	localparam logic [ADDR_W-1:0] EVENT_OPT_OFS     = 12'h008;
	localparam logic [ADDR_W-1:0] SECURE_MODE_OFS   = 12'h020;
	localparam logic [ADDR_W-1:0] PRIVILEGE_OFS     = 12'h024;
	localparam logic [ADDR_W-1:0] INT_ENABLE_OFS    = 12'h02C;
	localparam logic [ADDR_W-1:0] EVENT_STATUS_OFS  = 12'h030;
	localparam logic [ADDR_W-1:0] NS_MASKED_OFS     = 12'h034;
	localparam logic [ADDR_W-1:0] S_MASKED_OFS      = 12'h038;
	localparam logic [ADDR_W-1:0] STATUS_CLEAR_OFS  = 12'h03C;
	localparam logic [ADDR_W-1:0] BACKUP_BASE_OFS   = 12'h100;
	// ==========================================================
	// Field positions
	localparam int LEVEL_LSB   = 0;
	localparam int NOERASE_LSB = 8;
	localparam int TRIG_LSB    = 16;
	localparam int ZONE1_LSB   = 0;
	localparam int ZONE2_LSB   = 16;
	localparam int DPROT_BIT   = 31;
	localparam int Z1PRIV_BIT  = 0;
	localparam int Z2PRIV_BIT  = 1;
	localparam int PRIVONLY_BIT = 15;
	// ==========================================================
	// Reset values
	localparam logic [7:0] DETECT_ENABLE_RST = 8'hFF;
	localparam logic [7:0] FILTER_CFG_RST    = 8'h00;
	localparam logic [7:0] ZONE_END_RST      = 8'h00;
	localparam logic       DPROT_RST         = 1'b1;
	// ==========================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// ==========================================================
	// Types
	typedef struct packed {
		logic       pullup_dis;
		logic [1:0] prech;
		logic [1:0] count;
		logic [2:0] rate;
	} tdp_filt_t;
	typedef struct packed {
		logic nonsecure;
		logic privileged;
	} tdp_attr_t;
	typedef enum logic [2:0] {
		PM_RUN, PM_SLEEP, PM_LPRUN, PM_LPSLEEP, PM_STOP, PM_STANDBY, PM_SHUTDOWN
	} tdp_pmode_t;
	typedef enum logic [1:0] {CS_HSE_DIV, CS_LSE, CS_LSI} tdp_csrc_t;
endpackage : tdp_pkg

// *** src/tdp_top.sv ***
// Passive tamper detection, filter, event options and register protection.
// Assumes an AXI4-Lite master on ref_clk; arst_n is the backup-domain power-on reset.
// Contract
// (RL1) Precharge pulse of 1, 2, 4 or 8 cycles
// (RL2) Pull-up only during precharge pulse
// (RL3) Sample pin at end of precharge
// (RL4) Sampling rate 128 down to 1 Hz
// (RL5) Report after 1/2/4/8 consecutive active samples
// (RL6) Inactive sample restarts the consecutive count
// (RL7) Per-source interrupt enable
// (RL8) Per-pin choice to assert erase
// (RL9) Per-pin choice to trigger low-power timer
// (RL10) After power-on, all access open except secure control
// (RL11) Protection survives system reset, not power-on reset
// (RL12) Secure-only writes unless protect-disable set
// (RL13) Backup zone one: secure read and write
// (RL14) Backup zone two: any read, secure write
// (RL15) Backup zone three: any read and write
// (RL16) Zone ends from secure control fields
// (RL17) Privilege control privileged-only; privilege-only bit
// (RL18) Per-zone privilege bits for zones one, two
// (RL19) Enabled source event sets its status flag
// (RL20) Enables mask status into two masked views
// (RL21) Protect-disable selects non-secure or secure line
// (RL22) Wake from any mode; clock limits filtering
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tdp_top #(
	parameter int TICK_CYC = tdp_pkg::TICK_CYC
) (
	input  wire logic                       ref_clk,
	input  wire logic                       arst_n,
	input  wire logic                       sys_rst_n,
	input  wire logic [tdp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [tdp_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [7:0]                 tamp_in,
	output logic [7:0]                      pullup_en,
	input  wire logic                       security_ext_en,
	input  wire logic [2:0]                 power_mode,
	input  wire logic [1:0]                 tamp_clk_sel,
	output logic                            irq_ns,
	output logic                            irq_s,
	output logic                            wakeup,
	output logic                            erase_req,
	output logic [7:0]                      lptim_trig
);
	// ==========================================================
	// Input synchronisers
	logic [7:0]  pin_s1_reg, pin_s2_reg;
	logic [6:0]  misc_s1_reg, misc_s2_reg;
	logic        tz, sys_rst;
	tdp_pkg::tdp_pmode_t pmode;
	tdp_pkg::tdp_csrc_t  csrc;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_reg  <= 8'h00;
			pin_s2_reg  <= 8'h00;
			misc_s1_reg <= 7'h00;
			misc_s2_reg <= 7'h00;
		end else begin
			pin_s1_reg  <= tamp_in;
			pin_s2_reg  <= pin_s1_reg;
			misc_s1_reg <= {~sys_rst_n, security_ext_en, power_mode, tamp_clk_sel};
			misc_s2_reg <= misc_s1_reg;
		end
	end

	assign sys_rst = misc_s2_reg[6];
	assign tz      = misc_s2_reg[5];
	assign pmode   = tdp_pkg::tdp_pmode_t'(misc_s2_reg[4:2]);
	assign csrc    = tdp_pkg::tdp_csrc_t'(misc_s2_reg[1:0]);

	// ==========================================================
	// Functions
	function automatic logic [1:0] zone_of(input logic [4:0] idx, input logic [7:0] x, input logic [7:0] y);
		if ({3'h0, idx} < x)
			return 2'h1; // [RL13]
		else if ({3'h0, idx} < y)
			return 2'h2; // [RL14]
		else
			return 2'h3; // [RL15]
	endfunction : zone_of

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction : merge

	function automatic logic is_bkp(input logic [tdp_pkg::ADDR_W-1:0] a);
		return a >= tdp_pkg::BACKUP_BASE_OFS && a < tdp_pkg::BACKUP_BASE_OFS + 12'h080;
	endfunction : is_bkp

	// ==========================================================
	// Register state
	logic [7:0]  enable_reg, enable_next, level_reg, level_next, noerase_reg, noerase_next;
	logic [7:0]  trig_reg, trig_next, ier_reg, ier_next, sr_reg, sr_next;
	tdp_pkg::tdp_filt_t filt_reg, filt_next;
	logic [7:0]  z1_end_reg, z1_end_next, z2_end_reg, z2_end_next;
	logic        dprot_reg, dprot_next, privonly_reg, privonly_next;
	logic        z1priv_reg, z1priv_next, z2priv_reg, z2priv_next;
	logic [31:0] bkp_reg [tdp_pkg::N_BKP];
	logic [31:0] bkp_next [tdp_pkg::N_BKP];
	logic [7:0]  det, masked;
	logic        erase_now;

	// ==========================================================
	// AXI4-Lite slave
	logic                       aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [tdp_pkg::ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	tdp_pkg::tdp_attr_t         aw_attr_reg, aw_attr_next;
	logic [31:0]                w_data_reg, w_data_next;
	logic [3:0]                 w_strb_reg, w_strb_next;
	logic                       bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]                 bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0]                rdata_reg, rdata_next;
	logic                       do_wr, wr_ok, rd_ok, wr_map, rd_map;
	logic [1:0]                 wz, rz;
	logic [31:0]                rd_val;
	tdp_pkg::tdp_attr_t         ar_attr;

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign do_wr         = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign ar_attr       = '{nonsecure: s_axi_arprot[1], privileged: s_axi_arprot[0]};
	assign wz            = zone_of(aw_addr_reg[6:2], z1_end_reg, z2_end_reg);
	assign rz            = zone_of(s_axi_araddr[6:2], z1_end_reg, z2_end_reg);
	assign masked        = sr_reg & ier_reg; // [RL20]

	// Write permission
	always_comb begin
		wr_map = 1'b1;
		wr_ok  = 1'b1;
		if (is_bkp(aw_addr_reg)) begin
			if (tz && aw_attr_reg.nonsecure && wz != 2'h3)
				wr_ok = 1'b0; // [RL13] [RL14] [RL15]
			if (!aw_attr_reg.privileged && ((wz == 2'h1 && z1priv_reg) || (wz == 2'h2 && z2priv_reg)))
				wr_ok = 1'b0; // [RL18]
		end else begin
			unique case (aw_addr_reg)
				tdp_pkg::DETECT_ENABLE_OFS, tdp_pkg::FILTER_CFG_OFS, tdp_pkg::EVENT_OPT_OFS,
				tdp_pkg::INT_ENABLE_OFS, tdp_pkg::STATUS_CLEAR_OFS, tdp_pkg::SECURE_MODE_OFS,
				tdp_pkg::PRIVILEGE_OFS: wr_map = 1'b1;
				default: wr_map = 1'b0;
			endcase
			if (tz && aw_attr_reg.nonsecure && !dprot_reg)
				wr_ok = 1'b0; // [RL12]
			if (privonly_reg && !aw_attr_reg.privileged)
				wr_ok = 1'b0; // [RL17]
			if (aw_addr_reg == tdp_pkg::SECURE_MODE_OFS && tz && aw_attr_reg.nonsecure)
				wr_ok = 1'b0; // [RL10]
			if (aw_addr_reg == tdp_pkg::PRIVILEGE_OFS && !aw_attr_reg.privileged)
				wr_ok = 1'b0; // [RL17]
		end
	end

	// Read decode and permission
	always_comb begin
		rd_map = 1'b1;
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		if (is_bkp(s_axi_araddr)) begin
			rd_val = bkp_reg[s_axi_araddr[6:2]];
			if (tz && ar_attr.nonsecure && rz == 2'h1)
				rd_ok = 1'b0; // [RL13]
			if (!ar_attr.privileged && rz == 2'h1 && z1priv_reg)
				rd_ok = 1'b0; // [RL18]
		end else begin
			unique case (s_axi_araddr)
				tdp_pkg::DETECT_ENABLE_OFS: rd_val = {24'h0, enable_reg};
				tdp_pkg::FILTER_CFG_OFS:    rd_val = {24'h0, filt_reg};
				tdp_pkg::EVENT_OPT_OFS:     rd_val = {8'h0, trig_reg, noerase_reg, level_reg};
				tdp_pkg::SECURE_MODE_OFS:   rd_val = {dprot_reg, 7'h0, z2_end_reg, 8'h0, z1_end_reg};
				tdp_pkg::PRIVILEGE_OFS:     rd_val = {16'h0, privonly_reg, 13'h0, z2priv_reg, z1priv_reg};
				tdp_pkg::INT_ENABLE_OFS:    rd_val = {24'h0, ier_reg};
				tdp_pkg::EVENT_STATUS_OFS:  rd_val = {24'h0, sr_reg};
				tdp_pkg::NS_MASKED_OFS:     rd_val = {24'h0, dprot_reg ? masked : 8'h00}; // [RL20]
				tdp_pkg::S_MASKED_OFS:      rd_val = {24'h0, dprot_reg ? 8'h00 : masked}; // [RL20]
				tdp_pkg::STATUS_CLEAR_OFS:  rd_val = 32'h0000_0000;
				default:                    rd_map = 1'b0;
			endcase
		end
	end

	always_comb begin
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		aw_attr_next = aw_attr_reg;
		w_hold_next  = w_hold_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
			aw_attr_next = '{nonsecure: s_axi_awprot[1], privileged: s_axi_awprot[0]};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (do_wr) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = !wr_map ? tdp_pkg::RESP_DECERR : (wr_ok ? tdp_pkg::RESP_OKAY : tdp_pkg::RESP_SLVERR);
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next  = (rd_map && rd_ok) ? rd_val : 32'h0000_0000;
			rresp_next  = !rd_map ? tdp_pkg::RESP_DECERR : (rd_ok ? tdp_pkg::RESP_OKAY : tdp_pkg::RESP_SLVERR);
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			aw_attr_reg <= '0;
			w_hold_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= 2'h0;
			rdata_reg   <= 32'h0000_0000;
		end else begin
			aw_hold_reg <= aw_hold_next;
			aw_addr_reg <= aw_addr_next;
			aw_attr_reg <= aw_attr_next;
			w_hold_reg  <= w_hold_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ==========================================================
	// Control, protection, status and backup registers
	always_comb begin
		logic [31:0] wv;
		logic        wr;
		wr            = do_wr && wr_ok && wr_map;
		wv            = 32'h0000_0000;
		enable_next   = enable_reg;
		filt_next     = filt_reg;
		level_next    = level_reg;
		noerase_next  = noerase_reg;
		trig_next     = trig_reg;
		ier_next      = ier_reg;
		sr_next       = sr_reg;
		z1_end_next   = z1_end_reg;
		z2_end_next   = z2_end_reg;
		dprot_next    = dprot_reg;
		privonly_next = privonly_reg;
		z1priv_next   = z1priv_reg;
		z2priv_next   = z2priv_reg;
		bkp_next      = bkp_reg;
		if (wr) begin
			unique case (aw_addr_reg)
				tdp_pkg::DETECT_ENABLE_OFS: begin
					wv          = merge({24'h0, enable_reg}, w_data_reg, w_strb_reg);
					enable_next = wv[7:0];
				end
				tdp_pkg::FILTER_CFG_OFS: begin
					wv        = merge({24'h0, filt_reg}, w_data_reg, w_strb_reg);
					filt_next = wv[7:0];
				end
				tdp_pkg::EVENT_OPT_OFS: begin
					wv           = merge({8'h0, trig_reg, noerase_reg, level_reg}, w_data_reg, w_strb_reg);
					level_next   = wv[tdp_pkg::LEVEL_LSB +: 8];
					noerase_next = wv[tdp_pkg::NOERASE_LSB +: 8]; // [RL8]
					trig_next    = wv[tdp_pkg::TRIG_LSB +: 8]; // [RL9]
				end
				tdp_pkg::INT_ENABLE_OFS: begin
					wv       = merge({24'h0, ier_reg}, w_data_reg, w_strb_reg);
					ier_next = wv[7:0]; // [RL7]
				end
				tdp_pkg::STATUS_CLEAR_OFS: begin
					wv      = merge(32'h0000_0000, w_data_reg, w_strb_reg);
					sr_next = sr_reg & ~wv[7:0];
				end
				tdp_pkg::SECURE_MODE_OFS: begin
					wv          = merge({dprot_reg, 7'h0, z2_end_reg, 8'h0, z1_end_reg}, w_data_reg, w_strb_reg);
					z1_end_next = wv[tdp_pkg::ZONE1_LSB +: 8]; // [RL16]
					z2_end_next = wv[tdp_pkg::ZONE2_LSB +: 8]; // [RL16]
					dprot_next  = wv[tdp_pkg::DPROT_BIT];
				end
				tdp_pkg::PRIVILEGE_OFS: begin
					wv            = merge({16'h0, privonly_reg, 13'h0, z2priv_reg, z1priv_reg}, w_data_reg, w_strb_reg);
					privonly_next = wv[tdp_pkg::PRIVONLY_BIT]; // [RL17]
					z1priv_next   = wv[tdp_pkg::Z1PRIV_BIT]; // [RL18]
					z2priv_next   = wv[tdp_pkg::Z2PRIV_BIT]; // [RL18]
				end
				default: begin
					if (is_bkp(aw_addr_reg))
						bkp_next[aw_addr_reg[6:2]] = merge(bkp_reg[aw_addr_reg[6:2]], w_data_reg, w_strb_reg);
				end
			endcase
		end
		// Detection wins over a clear in the same cycle
		sr_next = sr_next | det; // [RL19]
		if (erase_now)
			for (int i = 0; i < tdp_pkg::N_BKP; i++)
				bkp_next[i] = 32'h0000_0000; // [RL8]
		// System reset leaves protection settings alone
		if (sys_rst) begin
			sr_next  = 8'h00; // [RL11]
			ier_next = 8'h00;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_reg   <= tdp_pkg::DETECT_ENABLE_RST;
			filt_reg     <= tdp_pkg::FILTER_CFG_RST;
			level_reg    <= 8'h00;
			noerase_reg  <= 8'h00;
			trig_reg     <= 8'h00;
			ier_reg      <= 8'h00;
			sr_reg       <= 8'h00;
			z1_end_reg   <= tdp_pkg::ZONE_END_RST; // [RL10] [RL11]
			z2_end_reg   <= tdp_pkg::ZONE_END_RST;
			dprot_reg    <= tdp_pkg::DPROT_RST; // [RL10]
			privonly_reg <= 1'b0;
			z1priv_reg   <= 1'b0;
			z2priv_reg   <= 1'b0;
			for (int i = 0; i < tdp_pkg::N_BKP; i++)
				bkp_reg[i] <= 32'h0000_0000;
		end else begin
			enable_reg   <= enable_next;
			filt_reg     <= filt_next;
			level_reg    <= level_next;
			noerase_reg  <= noerase_next;
			trig_reg     <= trig_next;
			ier_reg      <= ier_next;
			sr_reg       <= sr_next;
			z1_end_reg   <= z1_end_next;
			z2_end_reg   <= z2_end_next;
			dprot_reg    <= dprot_next;
			privonly_reg <= privonly_next;
			z1priv_reg   <= z1priv_next;
			z2priv_reg   <= z2priv_next;
			bkp_reg      <= bkp_next;
		end
	end

	assign irq_ns = dprot_reg && |masked; // [RL21]
	assign irq_s  = !dprot_reg && |masked; // [RL21]
	assign wakeup = irq_ns || irq_s; // [RL22]

	// ==========================================================
	// Sampling sequencer on the tamper time base
	typedef enum logic {SQ_WAIT, SQ_PRECH} tdp_seq_t;
	tdp_seq_t    seq_reg, seq_next;
	logic [15:0] tick_reg, tick_next;
	logic [15:0] rate_reg, rate_next;
	logic [2:0]  prech_reg, prech_next;
	logic        tick, filt_run, sample;
	logic [15:0] rate_top;
	logic [7:0]  erase_pend, trig_pend;

	always_comb begin
		unique case (pmode)
			tdp_pkg::PM_STOP, tdp_pkg::PM_STANDBY:
				filt_run = csrc == tdp_pkg::CS_LSE || csrc == tdp_pkg::CS_LSI; // [RL22]
			tdp_pkg::PM_SHUTDOWN:
				filt_run = csrc == tdp_pkg::CS_LSE; // [RL22]
			tdp_pkg::PM_RUN, tdp_pkg::PM_SLEEP, tdp_pkg::PM_LPRUN, tdp_pkg::PM_LPSLEEP:
				filt_run = 1'b1;
			default:
				filt_run = 1'b0;
		endcase
	end

	assign tick     = tick_reg == 16'(TICK_CYC - 1);
	assign rate_top = 16'((tdp_pkg::BASE_RATE_TK << filt_reg.rate) - 1); // [RL4]
	assign sample   = seq_reg == SQ_PRECH && tick && prech_reg == 3'h0; // [RL3]

	always_comb begin
		seq_next   = seq_reg;
		tick_next  = tick ? 16'h0000 : tick_reg + 16'h0001;
		rate_next  = rate_reg;
		prech_next = prech_reg;
		if (tick) begin
			rate_next = (rate_reg >= rate_top) ? 16'h0000 : rate_reg + 16'h0001;
			unique case (seq_reg)
				SQ_WAIT: begin
					if (rate_reg >= rate_top && filt_run) begin
						seq_next   = SQ_PRECH;
						prech_next = 3'((4'h1 << filt_reg.prech) - 4'h1); // [RL1]
					end
				end
				SQ_PRECH: begin
					if (prech_reg == 3'h0)
						seq_next = SQ_WAIT;
					else
						prech_next = prech_reg - 3'h1;
				end
			endcase
		end
		if (!filt_run)
			seq_next = SQ_WAIT;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_reg   <= SQ_WAIT;
			tick_reg  <= 16'h0000;
			rate_reg  <= 16'h0000;
			prech_reg <= 3'h0;
		end else begin
			seq_reg   <= seq_next;
			tick_reg  <= tick_next;
			rate_reg  <= rate_next;
			prech_reg <= prech_next;
		end
	end

	// ==========================================================
	// Per-pin consecutive-sample filters
	logic [3:0] thr;
	assign thr = 4'(4'h1 << filt_reg.count); // [RL5]

	for (genvar g = 0; g < tdp_pkg::N_PINS; g++) begin : g_pin
		logic [3:0] cnt_reg, cnt_next;
		logic       hit;
		always_comb begin
			cnt_next = cnt_reg;
			hit      = 1'b0;
			if (sample) begin
				if (pin_s2_reg[g] == level_reg[g] && enable_reg[g]) begin
					if (cnt_reg < thr) begin
						cnt_next = cnt_reg + 4'h1;
						hit      = cnt_reg + 4'h1 == thr; // [RL5]
					end
				end else begin
					cnt_next = 4'h0; // [RL6]
				end
			end
			if (sys_rst)
				cnt_next = 4'h0;
		end
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n)
				cnt_reg <= 4'h0;
			else
				cnt_reg <= cnt_next;
		end
		assign det[g]        = hit; // [RL19]
		assign erase_pend[g] = hit && !noerase_reg[g]; // [RL8]
		assign trig_pend[g]  = hit && trig_reg[g]; // [RL9]
		assign pullup_en[g]  = seq_reg == SQ_PRECH && !filt_reg.pullup_dis; // [RL2]
	end

	assign erase_now = |erase_pend;

	// ==========================================================
	// Event outputs
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			erase_req  <= 1'b0;
			lptim_trig <= 8'h00;
		end else begin
			erase_req  <= erase_now; // [RL8]
			lptim_trig <= trig_pend; // [RL9]
		end
	end
endmodule : tdp_top
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench: register access, protection and detection tests.
// Assumes TICK_CYC of 2 and a 40 MHz reference clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	localparam int TICK_CYC = 2;
	logic        ref_clk = 1'b0, arst_n = 1'b0, sys_rst_n = 1'b0, sec_en = 1'b1, pu_prev = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [2:0]  awprot = 3'h0, arprot = 3'h0, power_mode = 3'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp, clk_sel = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq_ns, irq_s, wakeup, erase_req;
	logic [7:0]  tamp_in, pullup_en, lptim_trig, sw_open = 8'h00;
	int          mismatches = 0, checks_done = 0, cycles = 0, pu_cnt = 0;
	always #12.5 ref_clk = ~ref_clk;
	tdp_top #(.TICK_CYC(TICK_CYC)) DUT (.ref_clk, .arst_n, .sys_rst_n,
		.s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tamp_in,
		.pullup_en, .security_ext_en(sec_en), .power_mode, .tamp_clk_sel(clk_sel),
		.irq_ns, .irq_s, .wakeup, .erase_req, .lptim_trig);
	tdp_switch u_sw (.ref_clk, .pullup_en, .sw_open, .tamp_in);
	// ==========================================================
	// Tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] p, input logic [1:0] er);
		@(posedge ref_clk);
		awaddr <= a;
		awprot <= p;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [2:0] p, input logic [1:0] er, input logic [31:0] ed);
		@(posedge ref_clk);
		araddr <= a;
		arprot <= p;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		`CHK(rdata, ed)
		`CHK(rresp, er)
	endtask : rd
	// ==========================================================
	// Sequence
	always @(posedge ref_clk) begin
		cycles++;
		if (pullup_en[0] && !pu_prev) pu_cnt++;
		pu_prev <= pullup_en[0];
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		sys_rst_n <= 1'b1;
		rd(12'h000, 3'h3, 2'h0, 32'hFF);
		rd(12'h020, 3'h3, 2'h0, 32'h8000_0000);
		rd(12'hFFC, 3'h3, 2'h3, 32'h0);
		wr(12'h000, 32'h01, 3'h3, 2'h0);
		wr(12'h004, 32'h28, 3'h3, 2'h0);
		wr(12'h008, 32'h1_0001, 3'h3, 2'h0);
		wr(12'h020, 32'h4_0002, 3'h3, 2'h2);
		wr(12'h114, 32'hA5, 3'h2, 2'h0);
		wr(12'h020, 32'h4_0002, 3'h1, 2'h0);
		wr(12'h100, 32'h1, 3'h3, 2'h2);
		rd(12'h100, 3'h3, 2'h2, 32'h0);
		wr(12'h100, 32'h11, 3'h1, 2'h0);
		rd(12'h100, 3'h1, 2'h0, 32'h11);
		rd(12'h108, 3'h3, 2'h0, 32'h0);
		wr(12'h108, 32'h1, 3'h3, 2'h2);
		wr(12'h110, 32'h5A, 3'h3, 2'h0);
		rd(12'h110, 3'h2, 2'h0, 32'h5A);
		wr(12'h000, 32'h1, 3'h3, 2'h2);
		wr(12'h024, 32'h8001, 3'h0, 2'h2);
		wr(12'h024, 32'h8001, 3'h1, 2'h0);
		wr(12'h02C, 32'h1, 3'h0, 2'h2);
		rd(12'h100, 3'h0, 2'h2, 32'h0);
		sys_rst_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		sys_rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(12'h024, 3'h1, 2'h0, 32'h8001);
		rd(12'h020, 3'h1, 2'h0, 32'h4_0002);
		wr(12'h02C, 32'h1, 3'h1, 2'h0);
		@(negedge pullup_en[0]);
		sw_open <= 8'h01;
		pu_cnt = 0;
		do @(posedge ref_clk); while (erase_req !== 1'b1);
		`CHK(lptim_trig, 8'h01)
		`CHK(pu_cnt, 2)
		rd(12'h038, 3'h1, 2'h0, 32'h1);
		rd(12'h034, 3'h1, 2'h0, 32'h0);
		`CHK(irq_s, 1'b1)
		rd(12'h114, 3'h1, 2'h0, 32'h0);
		wr(12'h03C, 32'h1, 3'h1, 2'h0);
		rd(12'h030, 3'h1, 2'h0, 32'h0);
		`CHK(irq_s, 1'b0)
		power_mode <= 3'h6;
		clk_sel <= 2'h2;
		repeat (1200) @(posedge ref_clk);
		conclude();
	end
endmodule : tb_top
bind tdp_top tdp_checker u_chk (.ref_clk, .arst_n, .s_axi_bvalid, .pullup_en, .power_mode, .tamp_clk_sel,
	.irq_ns, .irq_s, .wakeup, .erase_req, .lptim_trig);
`default_nettype wire

// *** verif/tdp_checker.sv ***
// Port assertions for the tamper block.
// Assumes binding onto tdp_top with one clock domain.
`timescale 1ns/100ps
`default_nettype none
module tdp_checker (
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic       s_axi_bvalid,
	input wire logic [7:0] pullup_en,
	input wire logic [2:0] power_mode,
	input wire logic [1:0] tamp_clk_sel,
	input wire logic       irq_ns,
	input wire logic       irq_s,
	input wire logic       wakeup,
	input wire logic       erase_req,
	input wire logic [7:0] lptim_trig
);
	localparam int PU_MAX = 40;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// Properties
	property p_pu_min; $rose(pullup_en[0]) |=> pullup_en[0]; endproperty
	property p_pu_max; $rose(pullup_en[0]) |-> ##[1:PU_MAX] !pullup_en[0]; endproperty
	property p_erase; erase_req |=> !erase_req; endproperty
	property p_trig; (lptim_trig != 8'h00) |=> (lptim_trig == 8'h00); endproperty
	property p_irq; !(irq_ns && irq_s); endproperty
	property p_wake; wakeup == (irq_ns | irq_s); endproperty
	property p_halt; (power_mode == 3'h6 && tamp_clk_sel == 2'h2 && $past(power_mode, 4) == 3'h6
		&& $past(tamp_clk_sel, 4) == 2'h2) |-> !erase_req; endproperty
	property p_irq_src; $rose(irq_ns | irq_s) |-> (erase_req || s_axi_bvalid); endproperty
	a_pu_min: assert property (p_pu_min) else $error("precharge pulse too short");
	a_pu_max: assert property (p_pu_max) else $error("precharge pulse too long");
	a_erase: assert property (p_erase) else $error("erase pulse too long");
	a_trig: assert property (p_trig) else $error("timer trigger too long");
	a_irq: assert property (p_irq) else $error("both interrupt lines high");
	a_wake: assert property (p_wake) else $error("wakeup differs from interrupts");
	a_halt: assert property (p_halt) else $error("detection without a usable clock");
	a_irq_src: assert property (p_irq_src) else $error("interrupt without a cause");
	c_erase: cover property (erase_req);
	c_irq: cover property (irq_s);
	c_pu: cover property ($rose(pullup_en[0]));
endmodule : tdp_checker
`default_nettype wire

// *** verif/tdp_switch.sv ***
// Anti-tamper switch model standing on the tamper pins.
// Assumes pullup_en high turns the pin pull-up on.
`timescale 1ns/100ps
`default_nettype none
module tdp_switch (
	input  wire logic       ref_clk,
	input  wire logic [7:0] pullup_en,
	input  wire logic [7:0] sw_open,
	output logic [7:0]      tamp_in
);
	logic [7:0] last_reg = 8'h00;
	// Closed: low; open: high if pulled up, else inverse of last level
	always_comb tamp_in = sw_open & (pullup_en | ~last_reg);
	always_ff @(posedge ref_clk) last_reg <= tamp_in;
endmodule : tdp_switch
`default_nettype wire
